// File: tbu_pkg.sv
// package for the timer time-base unit: widths, encodings, reset values
package tbu_pkg;

  // ---------------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------------
  localparam int          CNT_W       = 16;           // counter, reload, divider width
  localparam int          REP_W       = 8;            // repetition counter width
  localparam logic [15:0] CNT_RST     = 16'h0000;     // counter reset value
  localparam logic [15:0] ARR_RST     = 16'hFFFF;     // period reload reset value
  localparam logic [15:0] PSC_RST     = 16'h0000;     // divider ratio reset value
  localparam logic [7:0]  REP_RST     = 8'h00;        // repetition reset value
  localparam logic [15:0] ONE16       = 16'h0001;     // unit step for 16-bit math
  localparam logic [7:0]  ONE8        = 8'h01;        // unit step for 8-bit math

  // ---------------------------------------------------------------------
  // alignment field encodings
  // ---------------------------------------------------------------------
  localparam logic [1:0]  ALIGN_EDGE  = 2'h0;         // edge aligned
  localparam logic [1:0]  ALIGN_C1    = 2'h1;         // center, flags counting down
  localparam logic [1:0]  ALIGN_C2    = 2'h2;         // center, flags counting up
  localparam logic [1:0]  ALIGN_C3    = 2'h3;         // center, flags both ways

  // control bits from software
  typedef struct packed {
    logic       counter_enable;         // run the counter
    logic       dir_down;               // software direction, edge mode only
    logic [1:0] alignment_select;       // 00 edge, else center aligned
    logic       period_preload_enable;  // reload goes through preload
    logic       update_disable;         // suppress update events
    logic       update_request_select;  // software update leaves flag alone
  } tbu_ctrl_t;

  // write strobes with their data
  typedef struct packed {
    logic        cnt_we;                // write counter value
    logic        arr_we;                // write period reload preload
    logic        psc_we;                // write divider ratio preload
    logic        rep_we;                // write repetition preload
    logic [15:0] wdata;                 // data for 16-bit writes
  } tbu_wr_t;

endpackage

// File: tbu_core.sv
// timer time-base unit: counter, prescaler, reload, repetition, update logic
// What this block does
// - 16-bit counter, up/down/both, prescaled clock
// - counter, reload, divider readable/writable while running
// - reload preload; immediate unless preload enabled
// - overflow/underflow or software makes update unless disabled
// - count on tick while enabled, one cycle late
// - 16-bit divider, ratio buffered until update
// - upcount zero to reload, wrap, overflow
// - update after repetition plus one cycles
// - software update restarts counter and prescaler
// - update disable suppresses all update events
// - request select keeps software update flag clear
// - update reloads repetition, reload, divider; sets flag
// - downcount reload to zero, reload, underflow
// - downcount software update restarts from reload
// - new reload active before counter reload
// - center: overflow at reload-1, underflow at 1
// - nonzero alignment selects center; flag direction
// - center mode direction shown by hardware
// - center: update at overflow and underflow
// - center with updates disabled keeps counting
module tbu_core
#(
  parameter int REP_WIDTH = 8                        // repetition counter width
)(
  input  wire logic                 clk_i,           // kernel clock, 25 MHz
  input  wire logic                 rst_i,           // synchronous reset, high
  input  wire tbu_pkg::tbu_ctrl_t   ctrl_i,          // control bits
  input  wire tbu_pkg::tbu_wr_t     wr_i,            // register write strobes
  input  wire logic [REP_WIDTH-1:0] rep_wdata_i,     // repetition write data
  input  wire logic                 update_generate_i, // software update pulse
  input  wire logic                 flag_clear_i,    // clear update flag pulse
  output logic [15:0]               count_value_o,   // counter value
  output logic [15:0]               period_reload_o, // reload preload readback
  output logic [15:0]               divider_ratio_o, // divider preload readback
  output logic [REP_WIDTH-1:0]      repeat_count_o,  // repetition preload readback
  output logic                      dir_down_o,      // current direction
  output logic                      update_flag_o,   // sticky update flag
  output logic                      update_event_o,  // update event pulse
  output logic                      count_tick_o,    // counter tick pulse
  output logic                      cmp_flag_en_o    // compare flags allowed now
);
  import tbu_pkg::*;

  // refuse repetition widths the down counter cannot serve
  if (REP_WIDTH < 1 || REP_WIDTH > 16)
  begin : g_bad_rep
    $error("REP_WIDTH must be 1..16");
  end

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  logic [15:0]          arr_pre;      // reload preload copy
  logic [15:0]          arr_act;      // reload active copy
  logic [15:0]          psc_pre;      // divider preload
  logic [15:0]          psc_act;      // divider buffer in use
  logic [15:0]          psc_cnt;      // prescaler internal counter
  logic [REP_WIDTH-1:0] rep_pre;      // repetition preload
  logic [REP_WIDTH-1:0] rep_cnt;      // repetition down counter
  logic [15:0]          cnt;          // main counter
  logic                 en_q;         // enable delayed one cycle
  logic                 ctr_dn;       // center-mode direction, 1 = down
  logic                 uflag;        // sticky flag
  logic                 center;       // center aligned mode
  logic                 dn;           // effective direction
  logic                 tick;         // prescaler output
  logic                 ovf;          // overflow this tick
  logic                 unf;          // underflow this tick
  logic                 wrap;         // any overflow or underflow
  logic                 hw_upd;       // hardware update request
  logic                 update_event;          // update event
  logic [15:0]          next_cnt;     // counter next value
  logic [15:0]          new_arr;      // reload value seen by the counter

  // ---------------------------------------------------------------------
  // direction and wrap detection
  // ---------------------------------------------------------------------
  assign center = (ctrl_i.alignment_select != ALIGN_EDGE);
  assign dn     = center ? ctr_dn : ctrl_i.dir_down;
  assign tick   = en_q && (psc_cnt == psc_act);
  // edge up: wrap at reload; center up: overflow at reload-1
  assign ovf    = tick && !dn &&
                  (center ? (cnt >= arr_act - ONE16) : (cnt >= arr_act));
  assign unf    = tick && dn &&
                  (center ? (cnt <= ONE16) : (cnt == CNT_RST));
  assign wrap   = ovf || unf;
  // a wrap only becomes an update when repetitions are exhausted
  assign hw_upd = wrap && (rep_cnt == '0);
  assign update_event    = !ctrl_i.update_disable && (hw_upd || update_generate_i);
  // new reload enters before the counter reloads, so next period is right
  assign new_arr = (update_event && !ctrl_i.period_preload_enable) ? arr_pre :
                   (update_event ? arr_pre : arr_act);

  // ---------------------------------------------------------------------
  // enable delay: counting starts one cycle after enable
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      en_q <= 1'b0;
    else
      en_q <= ctrl_i.counter_enable;
  end

  // ---------------------------------------------------------------------
  // prescaler counter and ratio buffer
  // ---------------------------------------------------------------------
  // the ratio in use moves only on an update, so a write never cuts a period short
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      psc_cnt <= CNT_RST;
      psc_pre <= PSC_RST;
      psc_act <= PSC_RST;
    end
    else
    begin
      if (wr_i.psc_we)
        psc_pre <= wr_i.wdata;
      // software update restarts prescaler counter even if updates disabled
      if (update_generate_i)
        psc_cnt <= CNT_RST;
      else if (en_q)
        psc_cnt <= (psc_cnt == psc_act) ? CNT_RST : psc_cnt + ONE16;
      if (update_event)
        psc_act <= psc_pre;
    end
  end

  // ---------------------------------------------------------------------
  // auto-reload preload and active copy
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      arr_pre <= ARR_RST;
      arr_act <= ARR_RST;
    end
    else
    begin
      if (wr_i.arr_we)
        arr_pre <= wr_i.wdata;
      if (!ctrl_i.period_preload_enable)
        arr_act <= wr_i.arr_we ? wr_i.wdata : arr_pre;
      else if (update_event)
        arr_act <= arr_pre;
    end
  end

  // ---------------------------------------------------------------------
  // repetition counter
  // ---------------------------------------------------------------------
  // reloads on any software update, even a disabled one, so a restart gives a full count
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rep_pre <= '0;
      rep_cnt <= '0;
    end
    else
    begin
      if (wr_i.rep_we)
        rep_pre <= rep_wdata_i;
      if (update_event || update_generate_i)
        rep_cnt <= rep_pre;
      else if (wrap)
        rep_cnt <= (rep_cnt == '0) ? rep_pre : rep_cnt - 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // main counter next value
  // ---------------------------------------------------------------------
  // priority: counter write, then software restart, then tick
  always_comb
  begin
    next_cnt = cnt;
    if (wr_i.cnt_we)
      next_cnt = wr_i.wdata;
    else if (update_generate_i)
      // software restart: edge-mode down restarts from reload, others from zero
      next_cnt = (!center && dn) ? new_arr : CNT_RST;
    else if (tick)
    begin
      if (center)
        next_cnt = ovf ? new_arr : (unf ? CNT_RST :
                   (dn ? cnt - ONE16 : cnt + ONE16));
      else if (dn)
        next_cnt = unf ? new_arr : cnt - ONE16;
      else
        next_cnt = ovf ? CNT_RST : cnt + ONE16;
    end
  end

  // counter register; readback comes straight from this flop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt <= CNT_RST;
    else
      cnt <= next_cnt;
  end

  // ---------------------------------------------------------------------
  // center-mode direction held by hardware
  // ---------------------------------------------------------------------
  // edge mode or a software restart puts the turn back to counting up
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctr_dn <= 1'b0;
    else if (!center || update_generate_i)
      ctr_dn <= 1'b0;                                                    // restart counting up
    else if (ovf)
      ctr_dn <= 1'b1;
    else if (unf)
      ctr_dn <= 1'b0;
  end

  // ---------------------------------------------------------------------
  // sticky update flag: set wins over clear
  // ---------------------------------------------------------------------
  // a software update with request select set leaves the flag alone
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      uflag <= 1'b0;
    else if (update_event && !(update_generate_i && !hw_upd && ctrl_i.update_request_select))
      uflag <= 1'b1;
    else if (flag_clear_i)
      uflag <= 1'b0;
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  // reload, divider and repetition readbacks show the preload copies, which is what software last wrote
  assign count_value_o   = cnt;
  assign period_reload_o = arr_pre;
  assign divider_ratio_o = psc_pre;
  assign repeat_count_o  = rep_pre;
  assign dir_down_o      = dn;
  assign update_flag_o   = uflag;
  assign update_event_o  = update_event;
  assign count_tick_o    = tick;
  // compare flags per alignment mode and current direction
  assign cmp_flag_en_o   = !center ||
                           (ctrl_i.alignment_select == ALIGN_C3) ||
                           (ctrl_i.alignment_select == ALIGN_C1 && dn) ||
                           (ctrl_i.alignment_select == ALIGN_C2 && !dn);

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  a_tick_needs_en: assert property (@(posedge clk_i) disable iff (rst_i)
    count_tick_o |-> $past(ctrl_i.counter_enable))
    else $error("tick without enable");
  a_up_wrap_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (ovf && !center && !wr_i.cnt_we && !update_generate_i) |=> (cnt == CNT_RST))
    else $error("upcount did not wrap to zero");
  a_dn_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    (unf && !center && !wr_i.cnt_we && !update_generate_i) |=> (cnt == $past(new_arr)))
    else $error("downcount did not reload");
  a_update_disable_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_i.update_disable |-> !update_event_o)
    else $error("update while disabled");
  a_sw_update: assert property (@(posedge clk_i) disable iff (rst_i)
    (update_generate_i && !ctrl_i.update_disable) |-> update_event_o)
    else $error("software update lost");
  a_sw_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    (update_generate_i && !wr_i.cnt_we && !(dn && !center)) |=> (cnt == CNT_RST && psc_cnt == CNT_RST))
    else $error("software update did not restart");
  a_psc_buffered: assert property (@(posedge clk_i) disable iff (rst_i)
    !update_event |=> $stable(psc_act))
    else $error("divider changed without update");
  a_arr_preload: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_i.period_preload_enable && !update_event) |=> $stable(arr_act))
    else $error("reload changed without update");
  a_urs_noflag: assert property (@(posedge clk_i) disable iff (rst_i)
    (update_generate_i && !hw_upd && ctrl_i.update_request_select && !uflag) |=> !uflag)
    else $error("flag set by masked software update");
  a_ctr_turn: assert property (@(posedge clk_i) disable iff (rst_i)
    (center && ovf && !update_generate_i) |=> ctr_dn)
    else $error("center mode did not turn down");
  a_ctr_bottom: assert property (@(posedge clk_i) disable iff (rst_i)
    (center && unf && !wr_i.cnt_we && !update_generate_i) |=> (cnt == CNT_RST))
    else $error("center underflow did not restart at zero");
  a_cnt_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_i.cnt_we |=> (cnt == $past(wr_i.wdata)))
    else $error("counter write lost");
  a_hw_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (update_event && !update_generate_i) |=> update_flag_o)
    else $error("hardware update did not set flag");

endmodule

// File: test_tbu_core.sv
// self-checking bench for the timer time-base unit
module test_tbu_core;
  timeunit 1ns;
  timeprecision 1ps;
  import tbu_pkg::*;

  // ---------------------------------------------------------------
  // signals and bookkeeping
  // ---------------------------------------------------------------
  typedef struct {
    bit          chk_gap;               // check spacing from last event
    int          gap;                   // expected spacing in clocks
    bit          chk_cnt;               // check counter at the event
    logic [15:0] cnt;                   // expected counter value
  } tbu_note_t;

  logic        clk_i             = 1'b0;  // 25 MHz clock
  logic        rst_i             = 1'b1;  // synchronous reset
  tbu_ctrl_t   ctrl_i            = '0;    // control bits
  tbu_wr_t     wr_i              = '0;    // write strobes
  logic [7:0]  rep_wdata_i       = 8'h00; // repetition data
  logic        update_generate_i = 1'b0;  // software update
  logic        flag_clear_i      = 1'b0;  // flag clear
  logic [15:0] count_value_o;             // counter
  logic [15:0] period_reload_o;           // reload readback
  logic [15:0] divider_ratio_o;           // divider readback
  logic [7:0]  repeat_count_o;            // repetition readback
  logic        dir_down_o;                // direction
  logic        update_flag_o;             // sticky flag
  logic        update_event_o;            // update event
  logic        count_tick_o;              // counter tick
  logic        cmp_flag_en_o;             // compare flags allowed
  tbu_note_t   q[$];                      // expected events, oldest first
  tbu_note_t   nt;                        // note under check
  int          gap_ctr;                   // clocks since last event
  int          n_mismatch = 0;            // mismatches
  int          cmp_count  = 0;            // comparisons
  int          cur_p;                     // divider of current run
  int          m, r, rr, u, p, rp, i;     // scenario variables

`define chk(got, exp) \
  begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

  tbu_core #(.REP_WIDTH(8)) dut (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .ctrl_i            (ctrl_i),
    .wr_i              (wr_i),
    .rep_wdata_i       (rep_wdata_i),
    .update_generate_i (update_generate_i),
    .flag_clear_i      (flag_clear_i),
    .count_value_o     (count_value_o),
    .period_reload_o   (period_reload_o),
    .divider_ratio_o   (divider_ratio_o),
    .repeat_count_o    (repeat_count_o),
    .dir_down_o        (dir_down_o),
    .update_flag_o     (update_flag_o),
    .update_event_o    (update_event_o),
    .count_tick_o      (count_tick_o),
    .cmp_flag_en_o     (cmp_flag_en_o)
  );

  // half period of 20 ns
  always #20 clk_i = ~clk_i;

  // ---------------------------------------------------------------
  // monitor: each update event takes the oldest note; looked at on the
  // falling edge, where the event pulse and the counter stand settled
  // ---------------------------------------------------------------
  always @(negedge clk_i)
  begin
    if (!rst_i && update_event_o === 1'b1)
    begin
      gap_ctr <= 1;
      if (q.size() == 0)
        `chk(update_event_o, 1'b0)
      else
      begin
        nt = q.pop_front();
        if (nt.chk_gap)
          `chk(gap_ctr, nt.gap)
        if (nt.chk_cnt)
          `chk(count_value_o, nt.cnt)
      end
    end
    else
      gap_ctr <= gap_ctr + 1;
  end

  // ---------------------------------------------------------------
  // driver tasks
  // ---------------------------------------------------------------
  function automatic void note(bit cg, int g, bit cc, logic [15:0] c);
    q.push_back('{cg, g, cc, c});
  endfunction

  task automatic done(string s);
    $display("test %0s done at %0t", s, $time);
  endtask

  // one write pulse; sel 0 counter, 1 reload, 2 divider, 3 repetition
  task automatic wr(int sel, logic [15:0] d);
    @(posedge clk_i);
    wr_i <= '{sel == 0, sel == 1, sel == 2, sel == 3, d};
    rep_wdata_i <= d[7:0];
    @(posedge clk_i);
    wr_i <= '0;
  endtask

  task automatic ug();
    @(posedge clk_i);
    update_generate_i <= 1'b1;
    @(posedge clk_i);
    update_generate_i <= 1'b0;
  endtask

  // stopped counter: program reload r, divider, repetition, then load all
  task automatic setup(logic [1:0] al, bit dn, int pp, int rpp, bit pre);
    @(posedge clk_i);
    ctrl_i <= '{1'b0, dn, al, pre, 1'b0, 1'b0};
    cur_p = pp;
    wr(1, 16'(r));
    #1 `chk(period_reload_o, 16'(r))
    wr(2, 16'(pp));
    wr(3, 16'(rpp));
    #1 `chk(divider_ratio_o, 16'(pp))
    `chk(repeat_count_o, 8'(rpp))
    note(0, 0, 0, 16'h0000);
    ug();
    #1 `chk(count_value_o, (al != 2'h0 || !dn) ? 16'h0000 : 16'(r))
    `chk(dir_down_o, (al == 2'h0) ? dn : 1'b0)
    `chk(cmp_flag_en_o, (al == 2'h1) ? 1'b0 : 1'b1)
  endtask

  // enable, wait for all noted events under a bound, stop
  task automatic go(int lim);
    int k;
    @(posedge clk_i);
    ctrl_i.counter_enable <= 1'b1;
    #1 `chk(count_tick_o, 1'b0)
    @(posedge clk_i);
    #1 if (cur_p == 0) `chk(count_tick_o, 1'b1)
    for (k = 0; k < lim && q.size() != 0; k++)
      @(posedge clk_i);
    ctrl_i.counter_enable <= 1'b0;
    `chk(q.size(), 0)
    q.delete();
    done("run");
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(51));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 `chk(period_reload_o, ARR_RST)
    `chk(count_value_o, CNT_RST)
    // up, down, three center modes; reload kept >= 5 so a stop lands between events
    for (m = 0; m < 5; m++)
    begin
      r = 5 + $urandom % 4;
      rp = (m < 2) ? $urandom % 3 : 0;
      p = $urandom % 3;
      setup((m < 2) ? 2'h0 : 2'(m - 1), m[0], p, rp, 1'b0);
      for (i = 0; i < 5; i++)
        note(i > 0, ((m < 2) ? (rp + 1) * (r + 1) : r) * (p + 1), 1,
             (m == 0) ? 16'(r) : (m == 1) ? 16'h0000 : i[0] ? 16'h0001 : 16'(r - 1));
      go(7 * (rp + 1) * (r + 1) * (p + 1) + 50);
    end
    // preloaded reload: old length until the update, new one after
    for (m = 0; m < 2; m++)
    begin
      r = 5 + $urandom % 4;
      rr = r + 3;
      setup(2'h0, m[0], 0, 0, 1'b1);
      wr(1, 16'(rr));
      note(0, 0, 1, m[0] ? 16'h0000 : 16'(r));
      note(1, rr + 1, 1, m[0] ? 16'h0000 : 16'(rr));
      go(4 * rr + 50);
    end
    // updates blocked: counting goes on, software update only restarts
    for (m = 0; m < 2; m++)
    begin
      r = 5;
      setup(2'(3 * m), 1'b0, 0, 0, 1'b0);
      @(posedge clk_i);
      ctrl_i <= '{1'b1, 1'b0, 2'(3 * m), 1'b0, 1'b1, 1'b0};
      repeat (30)
      begin
        @(posedge clk_i);
        #1 `chk(count_value_o <= 16'(r), 1'b1)
      end
      wr(0, 16'h0002);
      #1 `chk(count_value_o, 16'h0002)
      ug();
      #1 `chk(count_value_o, 16'h0000)
      @(posedge clk_i);
      ctrl_i <= '0;
      done("blocked");
    end
    // software update with and without the request-select bit
    for (u = 0; u < 2; u++)
    begin
      @(posedge clk_i);
      flag_clear_i <= 1'b1;
      ctrl_i.update_request_select <= 1'(1 - u);
      @(posedge clk_i);
      flag_clear_i <= 1'b0;
      #1 `chk(update_flag_o, 1'b0)
      note(0, 0, 0, 16'h0000);
      ug();
      #1 `chk(update_flag_o, 1'(u))
      done("flag");
    end
    print_verdict();
  end

  // watchdog at 20000 clocks, far beyond the under 2000 clocks the tests need
  initial
  begin
    #(40 * 20000);
    n_mismatch++;
    print_verdict();
  end

endmodule
